// *** core/mesf_pkg.sv ***
// package of the metering event status flag block
// assumes a 16-bit word address port that carries the printed offsets
package mesf_pkg;

  // register word addresses
  localparam logic [15:0] ADDR_EVT_ST0    = 16'he502;
  localparam logic [15:0] ADDR_EVT_ST1    = 16'he503;
  localparam logic [15:0] ADDR_ENA0       = 16'he50a;
  localparam logic [15:0] ADDR_ENA1       = 16'he50b;
  localparam logic [15:0] ADDR_MEAS_MODE  = 16'he700;
  localparam logic [15:0] ADDR_PULSE_MODE = 16'he701;
  localparam logic [15:0] ADDR_SIGNS      = 16'he702;
  localparam logic [15:0] ADDR_NOLOAD     = 16'he703;

  // status 0 bit positions
  localparam int ST0_SUM1   = 9;
  localparam int ST0_REACT  = 10;
  localparam int ST0_SUM2   = 13;
  localparam int ST0_PULSE  = 14;
  localparam int ST0_DONE   = 17;
  localparam int ST0_SUM3   = 18;
  localparam int ST0_WIDTH  = 19;

  // status 1 bit positions
  localparam int ST1_TOT_NL  = 0;
  localparam int ST1_FUND_NL = 1;
  localparam int ST1_APP_NL  = 2;
  localparam int ST1_VTO    = 3;
  localparam int ST1_ITO    = 6;
  localparam int ST1_VZX    = 9;
  localparam int ST1_IZXA   = 12;
  localparam int ST1_WIDTH  = 13;

  // phase sign register positions
  localparam int SGN_SUM1   = 3;
  localparam int SGN_REACT  = 4;
  localparam int SGN_SUM2   = 7;
  localparam int SGN_SUM3   = 8;
  localparam int SGN_WIDTH  = 9;

  // measurement mode and pulse mode fields
  localparam int MM_REACT_SEL = 1;
  localparam int MM_WIDTH     = 2;
  localparam int CF_SEL1      = 0;
  localparam int CF_SEL2      = 3;
  localparam int CF_SEL3      = 6;
  localparam int CF_DIS1      = 9;
  localparam int CF_WIDTH     = 12;

  // no-load phase register fields
  localparam int NL_TOTAL   = 0;
  localparam int NL_FUND    = 3;
  localparam int NL_APPAR   = 6;
  localparam int NL_WIDTH   = 9;

  // reset values
  localparam logic [31:0] RST_MASK   = 32'h0000_0000;
  localparam logic [1:0]  RST_MEAS_MODE  = 2'h0;
  localparam logic [11:0] RST_PULSE_MODE = 12'h000;

endpackage : mesf_pkg

// *** core/mesf_flag_bank.sv ***
// bank of sticky event flags, cleared by writing one
// assumes set and clear come from logic on the same clock
module mesf_flag_bank #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // events and clears
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  // flags
  output logic      [W-1:0] flags_ff
);

  logic [W-1:0] nxt_flags;

  // set wins over a clear in the same cycle
  assign nxt_flags = set_in | (flags_ff & ~clr_in);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

endmodule : mesf_flag_bank

// *** core/mesf_core.sv ***
// event status flags, masks and interrupt request of the metering core
// assumes all event inputs come from dsp logic on clk, no crossing needed
module mesf_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // power signs, one means negative
  input  wire logic        sum1_sign_a,
  input  wire logic        sum2_sign_b,
  input  wire logic        sum3_sign_c,
  input  wire logic [2:0]  total_reactive_sign,
  input  wire logic [2:0]  fund_reactive_sign,
  // raw pulse levels from the pulse generators, idle high
  input  wire logic [2:0]  pulse_raw,
  // dsp cycle done strobe
  input  wire logic        compute_cycle_done,
  // no-load phase levels
  input  wire logic [2:0]  total_noload_phases,
  input  wire logic [2:0]  fundamental_noload_phases,
  input  wire logic [2:0]  apparent_noload_phases,
  // zero crossing strobes, phase a in bit 0
  input  wire logic [2:0]  volt_crossing_timeout,
  input  wire logic [2:0]  curr_crossing_timeout,
  input  wire logic [2:0]  volt_crossing_seen,
  input  wire logic        curr_a_crossing_seen,
  // pulse pins, active low
  output logic             pulse_out_1_n,
  output logic             pulse_out_2_n,
  output logic             pulse_out_3_n,
  // power selects toward the pulse datapaths
  output logic      [2:0]  pulse1_power_select,
  output logic      [2:0]  pulse2_power_select,
  output logic      [2:0]  pulse3_power_select,
  // interrupt request, active low
  output logic             interrupt_request_out_n
);

  // software registers
  logic [31:0] event_enable_zero_ff;
  logic [31:0] event_enable_one_ff;
  logic [1:0]  measurement_mode_ff;
  logic [11:0] pulse_output_mode_ff;
  logic [31:0] rdata_ff;

  // tracked state
  logic [8:0]  phase_sign_ff;
  logic [8:0]  noload_prev_ff;
  logic [2:0]  pulse_prev_ff;
  logic [2:0]  pulse_pin_ff;
  logic        irq_n_ff;

  // flags
  logic [18:0] st0_flags;
  logic [12:0] st1_flags;

  // address decode
  wire hit_st0  = reg_addr == mesf_pkg::ADDR_EVT_ST0;
  wire hit_st1  = reg_addr == mesf_pkg::ADDR_EVT_ST1;
  wire hit_msk0 = reg_addr == mesf_pkg::ADDR_ENA0;
  wire hit_msk1 = reg_addr == mesf_pkg::ADDR_ENA1;
  wire hit_mm   = reg_addr == mesf_pkg::ADDR_MEAS_MODE;
  wire hit_cf   = reg_addr == mesf_pkg::ADDR_PULSE_MODE;
  wire hit_sgn  = reg_addr == mesf_pkg::ADDR_SIGNS;
  wire hit_nl   = reg_addr == mesf_pkg::ADDR_NOLOAD;

  wire wr_st0  = reg_wr & hit_st0;
  wire wr_st1  = reg_wr & hit_st1;
  wire wr_msk0 = reg_wr & hit_msk0;
  wire wr_msk1 = reg_wr & hit_msk1;
  wire wr_mm   = reg_wr & hit_mm;
  wire wr_cf   = reg_wr & hit_cf;

  // reactive sign source, zero total, one fundamental
  wire reactive_sign_source_select =
    measurement_mode_ff[mesf_pkg::MM_REACT_SEL];
  wire [2:0] react_sign = reactive_sign_source_select ?
    fund_reactive_sign : total_reactive_sign;

  // new value of the phase sign register
  logic [8:0] nxt_phase_sign;
  always_comb begin
    nxt_phase_sign = '0;
    nxt_phase_sign[mesf_pkg::SGN_SUM1] = sum1_sign_a;
    nxt_phase_sign[mesf_pkg::SGN_REACT +: 3] = react_sign;
    nxt_phase_sign[mesf_pkg::SGN_SUM2] = sum2_sign_b;
    nxt_phase_sign[mesf_pkg::SGN_SUM3] = sum3_sign_c;
  end

  // sign changes against the stored signs
  wire [8:0] sign_flip = nxt_phase_sign ^ phase_sign_ff;
  wire sum1_sign_flip = sign_flip[mesf_pkg::SGN_SUM1];
  wire sum2_sign_flip = sign_flip[mesf_pkg::SGN_SUM2];
  wire sum3_sign_flip = sign_flip[mesf_pkg::SGN_SUM3];
  wire phase_a_reactive_sign_flip = sign_flip[mesf_pkg::SGN_REACT];
  wire phase_b_reactive_sign_flip = sign_flip[mesf_pkg::SGN_REACT+1];
  wire phase_c_reactive_sign_flip = sign_flip[mesf_pkg::SGN_REACT+2];

  // pulse falling edges, counted even while the pin is disabled
  wire [2:0] pulse_fall = pulse_prev_ff & ~pulse_raw;

  // disables from the pulse mode register
  wire pulse1_disable = pulse_output_mode_ff[mesf_pkg::CF_DIS1];
  wire pulse2_disable = pulse_output_mode_ff[mesf_pkg::CF_DIS1+1];
  wire pulse3_disable = pulse_output_mode_ff[mesf_pkg::CF_DIS1+2];
  wire [2:0] pulse_disable = {pulse3_disable, pulse2_disable,
                              pulse1_disable};

  // disabled pins rest high
  wire [2:0] nxt_pulse_pin = pulse_raw | pulse_disable;

  // no-load entry per phase
  logic [8:0] noload_now;
  always_comb begin
    noload_now = '0;
    noload_now[mesf_pkg::NL_TOTAL +: 3] = total_noload_phases;
    noload_now[mesf_pkg::NL_FUND  +: 3] = fundamental_noload_phases;
    noload_now[mesf_pkg::NL_APPAR +: 3] = apparent_noload_phases;
  end
  wire [8:0] noload_entry = noload_now & ~noload_prev_ff;
  wire total_noload_flag =
    |noload_entry[mesf_pkg::NL_TOTAL +: 3];
  wire fundamental_noload_flag =
    |noload_entry[mesf_pkg::NL_FUND +: 3];
  wire apparent_noload_flag =
    |noload_entry[mesf_pkg::NL_APPAR +: 3];

  // status 0 event vector
  logic [18:0] st0_set;
  always_comb begin
    st0_set = '0;
    st0_set[mesf_pkg::ST0_SUM1]       = sum1_sign_flip;
    st0_set[mesf_pkg::ST0_REACT]      = phase_a_reactive_sign_flip;
    st0_set[mesf_pkg::ST0_REACT+1]    = phase_b_reactive_sign_flip;
    st0_set[mesf_pkg::ST0_REACT+2]    = phase_c_reactive_sign_flip;
    st0_set[mesf_pkg::ST0_SUM2]       = sum2_sign_flip;
    st0_set[mesf_pkg::ST0_PULSE +: 3] = pulse_fall;
    st0_set[mesf_pkg::ST0_DONE]       = compute_cycle_done;
    st0_set[mesf_pkg::ST0_SUM3]       = sum3_sign_flip;
  end

  // status 1 event vector
  logic [12:0] st1_set;
  always_comb begin
    st1_set = '0;
    st1_set[mesf_pkg::ST1_TOT_NL]  = total_noload_flag;
    st1_set[mesf_pkg::ST1_FUND_NL] = fundamental_noload_flag;
    st1_set[mesf_pkg::ST1_APP_NL]  = apparent_noload_flag;
    st1_set[mesf_pkg::ST1_VTO +: 3] = volt_crossing_timeout;
    st1_set[mesf_pkg::ST1_ITO +: 3] = curr_crossing_timeout;
    st1_set[mesf_pkg::ST1_VZX +: 3] = volt_crossing_seen;
    st1_set[mesf_pkg::ST1_IZXA]     = curr_a_crossing_seen;
  end

  // write-one clears
  wire [18:0] st0_clr = wr_st0 ? reg_wdata[18:0] : '0;
  wire [12:0] st1_clr = wr_st1 ? reg_wdata[12:0] : '0;

  mesf_flag_bank #(
    .W (mesf_pkg::ST0_WIDTH)
  ) u_st0_bank (
    .clk      (clk),
    .resetn   (resetn),
    .set_in   (st0_set),
    .clr_in   (st0_clr),
    .flags_ff (st0_flags)
  );

  mesf_flag_bank #(
    .W (mesf_pkg::ST1_WIDTH)
  ) u_st1_bank (
    .clk      (clk),
    .resetn   (resetn),
    .set_in   (st1_set),
    .clr_in   (st1_clr),
    .flags_ff (st1_flags)
  );

  // full register views, upper bits read zero
  wire [31:0] event_status_zero = {13'h0000, st0_flags};
  wire [31:0] event_status_one  = {19'h00000, st1_flags};

  // interrupt request, low while any enabled flag is pending
  wire pending = |(event_status_zero & event_enable_zero_ff) |
                 |(event_status_one  & event_enable_one_ff);
  wire nxt_irq_n = ~pending;

  // read selection
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (hit_st0) begin
        nxt_rdata = event_status_zero;
      end else if (hit_st1) begin
        nxt_rdata = event_status_one;
      end else if (hit_msk0) begin
        nxt_rdata = event_enable_zero_ff;
      end else if (hit_msk1) begin
        nxt_rdata = event_enable_one_ff;
      end else if (hit_mm) begin
        nxt_rdata = {30'h0000_0000, measurement_mode_ff};
      end else if (hit_cf) begin
        nxt_rdata = {20'h00000, pulse_output_mode_ff};
      end else if (hit_sgn) begin
        nxt_rdata = {23'h000000, phase_sign_ff};
      end else if (hit_nl) begin
        nxt_rdata = {23'h000000, noload_now};
      end
    end
  end

  // software registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      event_enable_zero_ff <= mesf_pkg::RST_MASK;
      event_enable_one_ff  <= mesf_pkg::RST_MASK;
    end else begin
      if (wr_msk0) begin
        event_enable_zero_ff <= reg_wdata;
      end
      if (wr_msk1) begin
        event_enable_one_ff <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      measurement_mode_ff  <= mesf_pkg::RST_MEAS_MODE;
      pulse_output_mode_ff <= mesf_pkg::RST_PULSE_MODE;
    end else begin
      if (wr_mm) begin
        measurement_mode_ff <= reg_wdata[1:0];
      end
      if (wr_cf) begin
        pulse_output_mode_ff <= reg_wdata[11:0];
      end
    end
  end

  // tracked state and pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_sign_ff  <= '0;
      noload_prev_ff <= '0;
      pulse_prev_ff  <= 3'h7;
      pulse_pin_ff   <= 3'h7;
      irq_n_ff       <= 1'b1;
      rdata_ff       <= 32'h0000_0000;
    end else begin
      phase_sign_ff  <= nxt_phase_sign;
      noload_prev_ff <= noload_now;
      pulse_prev_ff  <= pulse_raw;
      pulse_pin_ff   <= nxt_pulse_pin;
      irq_n_ff       <= nxt_irq_n;
      rdata_ff       <= nxt_rdata;
    end
  end

  // outputs
  assign reg_rdata               = rdata_ff;
  assign pulse_out_1_n           = pulse_pin_ff[0];
  assign pulse_out_2_n           = pulse_pin_ff[1];
  assign pulse_out_3_n           = pulse_pin_ff[2];
  assign pulse1_power_select     =
    pulse_output_mode_ff[mesf_pkg::CF_SEL1 +: 3];
  assign pulse2_power_select     =
    pulse_output_mode_ff[mesf_pkg::CF_SEL2 +: 3];
  assign pulse3_power_select     =
    pulse_output_mode_ff[mesf_pkg::CF_SEL3 +: 3];
  assign interrupt_request_out_n = irq_n_ff;

endmodule : mesf_core

// *** verif/mesf_monitor.sv ***
// assertion checker of the metering event status flag block
// assumes a bind onto mesf_core, one clock, async active-low reset
module mesf_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // events
  input wire logic        sum1_sign_a,
  input wire logic [2:0]  pulse_raw,
  input wire logic        compute_cycle_done,
  // outputs
  input wire logic        pulse_out_1_n,
  input wire logic        pulse_out_2_n,
  input wire logic        pulse_out_3_n,
  input wire logic [2:0]  pulse1_power_select,
  input wire logic [2:0]  pulse2_power_select,
  input wire logic [2:0]  pulse3_power_select,
  input wire logic        interrupt_request_out_n
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // status 0, enable and pulse mode accesses
  wire logic rd0 = reg_rd && reg_addr == mesf_pkg::ADDR_EVT_ST0;
  wire logic wr0 = reg_wr && reg_addr == mesf_pkg::ADDR_EVT_ST0;
  wire logic wz  = reg_wr && reg_wdata == 32'h0000_0000;
  wire logic wm0 = wz && reg_addr == mesf_pkg::ADDR_ENA0;
  wire logic wm1 = wz && reg_addr == mesf_pkg::ADDR_ENA1;
  wire logic wcf = reg_wr && reg_addr == mesf_pkg::ADDR_PULSE_MODE;

  a_reserved_zero: assert property (rd0 |=> reg_rdata[31:19] == 13'h0)
    else $error("status 0 reserved bits not zero");
  a_pulse1_fall: assert property (
    $fell(pulse_out_1_n) |-> !$past(pulse_raw[0]))
    else $error("pulse pin 1 fell without raw pulse");
  a_pulse2_fall: assert property (
    $fell(pulse_out_2_n) |-> !$past(pulse_raw[1]))
    else $error("pulse pin 2 fell without raw pulse");
  a_pulse3_fall: assert property (
    $fell(pulse_out_3_n) |-> !$past(pulse_raw[2]))
    else $error("pulse pin 3 fell without raw pulse");
  a_select_load: assert property (wcf |=> {pulse3_power_select,
    pulse2_power_select, pulse1_power_select} == $past(reg_wdata[8:0]))
    else $error("power selects differ from written field");
  a_done_flag: assert property (
    compute_cycle_done ##1 rd0 |=> reg_rdata[17])
    else $error("done flag not read back");
  a_sum1_flag: assert property (
    $changed(sum1_sign_a) ##1 rd0 |=> reg_rdata[9])
    else $error("sum1 sign change flag missing");
  a_clear_one: assert property (
    wr0 && reg_wdata[17] && !compute_cycle_done ##1 !compute_cycle_done
    ##1 (rd0 && !compute_cycle_done) |=> !reg_rdata[17])
    else $error("flag survived write one");
  a_mask_off_irq: assert property (
    wm0 ##2 wm1 |-> ##2 interrupt_request_out_n)
    else $error("irq low with all masks zero");
endmodule : mesf_monitor

// *** verif/testbench.sv ***
// self-checking bench of the metering event status flag block
// assumes mesf_core and mesf_pkg compiled before, checker bound below
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, reg_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        sum1_sign_a, sum2_sign_b, sum3_sign_c, compute_cycle_done;
  logic        curr_a_crossing_seen, interrupt_request_out_n;
  logic [2:0]  total_reactive_sign, fund_reactive_sign, pulse_raw;
  logic [2:0]  total_noload_phases, fundamental_noload_phases;
  logic [2:0]  apparent_noload_phases, volt_crossing_timeout;
  logic [2:0]  curr_crossing_timeout, volt_crossing_seen;
  logic        pulse_out_1_n, pulse_out_2_n, pulse_out_3_n;
  logic [2:0]  pulse1_power_select, pulse2_power_select, pulse3_power_select;
  int          num_errors, samples_checked;
  localparam logic [15:0] S0 = mesf_pkg::ADDR_EVT_ST0;
  localparam logic [15:0] S1 = mesf_pkg::ADDR_EVT_ST1;
  localparam logic [31:0] ONES = 32'hffff_ffff;
  wire [8:0] sel_all = {pulse3_power_select, pulse2_power_select,
                        pulse1_power_select};
  wire [3:0] out_pins = {pulse_out_3_n, pulse_out_2_n, pulse_out_1_n,
                         interrupt_request_out_n};

  mesf_core i_mesf_core (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sum1_sign_a(sum1_sign_a), .sum2_sign_b(sum2_sign_b),
    .sum3_sign_c(sum3_sign_c), .total_reactive_sign(total_reactive_sign),
    .fund_reactive_sign(fund_reactive_sign), .pulse_raw(pulse_raw),
    .compute_cycle_done(compute_cycle_done),
    .total_noload_phases(total_noload_phases),
    .fundamental_noload_phases(fundamental_noload_phases),
    .apparent_noload_phases(apparent_noload_phases),
    .volt_crossing_timeout(volt_crossing_timeout),
    .curr_crossing_timeout(curr_crossing_timeout),
    .volt_crossing_seen(volt_crossing_seen),
    .curr_a_crossing_seen(curr_a_crossing_seen),
    .pulse_out_1_n(pulse_out_1_n), .pulse_out_2_n(pulse_out_2_n),
    .pulse_out_3_n(pulse_out_3_n), .pulse1_power_select(pulse1_power_select),
    .pulse2_power_select(pulse2_power_select),
    .pulse3_power_select(pulse3_power_select),
    .interrupt_request_out_n(interrupt_request_out_n)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge clk);
  endtask : rd

  // pins then irq, settled after the edge
  task automatic chk_out(input logic [3:0] e);
    #1;
    `CHK(out_pins, e)
    @(posedge clk);
  endtask : chk_out

  task automatic s_reset;
    chk_out(4'hf);
    `CHK(sel_all, 9'h0)
    rd(S0, 32'h0);
    rd(S1, 32'h0);
    rd(mesf_pkg::ADDR_ENA0, 32'h0);
    wr(16'h1234, ONES);
    rd(16'h1234, 32'h0);
  endtask : s_reset

  task automatic s_sign;
    {sum3_sign_c, sum2_sign_b, sum1_sign_a} <= 3'h7;
    total_reactive_sign <= 3'h7;
    @(posedge clk);
    rd(S0, 32'h0004_3e00);
    rd(mesf_pkg::ADDR_SIGNS, 32'h0000_01f8);
    wr(S0, 32'h0);
    rd(S0, 32'h0004_3e00);
    wr(S0, 32'h0000_0200);
    rd(S0, 32'h0004_3c00);
    wr(S0, ONES);
    rd(S0, 32'h0);
    fund_reactive_sign <= 3'h7;
    wr(mesf_pkg::ADDR_MEAS_MODE, 32'h0000_0002);
    fund_reactive_sign <= 3'h5;
    @(posedge clk);
    rd(S0, 32'h0000_0800);
    rd(mesf_pkg::ADDR_SIGNS, 32'h0000_01d8);
    wr(S0, ONES);
    rd(mesf_pkg::ADDR_MEAS_MODE, 32'h0000_0002);
  endtask : s_sign

  task automatic s_pulse;
    for (int i = 0; i < 3; i++) begin
      pulse_raw <= ~(3'h1 << i);
      @(posedge clk);
      pulse_raw <= 3'h7;
      chk_out({~(3'h1 << i), 1'b1});
      rd(S0, 32'h0000_4000 << i);
      wr(S0, ONES);
    end
    wr(mesf_pkg::ADDR_PULSE_MODE, 32'h0000_0ed1);
    `CHK(sel_all, 9'h0d1)
    rd(mesf_pkg::ADDR_PULSE_MODE, 32'h0000_0ed1);
    pulse_raw <= 3'h0;
    @(posedge clk);
    pulse_raw <= 3'h7;
    chk_out(4'hf);
    rd(S0, 32'h0001_c000);
    wr(S0, ONES);
  endtask : s_pulse

  task automatic s_event_status_one;
    total_noload_phases <= 3'h1;
    apparent_noload_phases <= 3'h4;
    {volt_crossing_timeout, curr_crossing_timeout} <= 6'h2a;
    {volt_crossing_seen, curr_a_crossing_seen} <= 4'hd;
    @(posedge clk);
    {volt_crossing_timeout, curr_crossing_timeout} <= 6'h0;
    {volt_crossing_seen, curr_a_crossing_seen} <= 4'h0;
    rd(S1, 32'h0000_1cad);
    rd(mesf_pkg::ADDR_NOLOAD, 32'h0000_0101);
    wr(S1, ONES);
    fundamental_noload_phases <= 3'h2;
    {volt_crossing_timeout, curr_crossing_timeout} <= 6'h15;
    volt_crossing_seen <= 3'h1;
    @(posedge clk);
    {volt_crossing_timeout, curr_crossing_timeout} <= 6'h0;
    volt_crossing_seen <= 3'h0;
    rd(S1, 32'h0000_0352);
    wr(S1, ONES);
  endtask : s_event_status_one

  task automatic s_irq;
    wr(mesf_pkg::ADDR_ENA0, 32'h0002_0000);
    rd(mesf_pkg::ADDR_ENA0, 32'h0002_0000);
    compute_cycle_done <= 1'b1;
    @(posedge clk);
    compute_cycle_done <= 1'b0;
    rd(S0, 32'h0002_0000);
    chk_out(4'he);
    wr(S0, 32'h0002_0000);
    chk_out(4'hf);
    wr(mesf_pkg::ADDR_ENA1, 32'h0000_1000);
    rd(mesf_pkg::ADDR_ENA1, 32'h0000_1000);
    curr_a_crossing_seen <= 1'b1;
    @(posedge clk);
    curr_a_crossing_seen <= 1'b0;
    @(posedge clk);
    chk_out(4'he);
    wr(mesf_pkg::ADDR_ENA0, 32'h0);
    wr(mesf_pkg::ADDR_ENA1, 32'h0);
    chk_out(4'hf);
    wr(S1, ONES);
  endtask : s_irq

  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, resetn} = '0;
    {sum1_sign_a, sum2_sign_b, sum3_sign_c, compute_cycle_done} = '0;
    {total_reactive_sign, fund_reactive_sign, curr_a_crossing_seen} = '0;
    {total_noload_phases, fundamental_noload_phases} = '0;
    {apparent_noload_phases, volt_crossing_timeout} = '0;
    {curr_crossing_timeout, volt_crossing_seen} = '0;
    pulse_raw = 3'h7;
    num_errors = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    s_reset;
    s_sign;
    s_pulse;
    s_event_status_one;
    s_irq;
    give_verdict;
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("[ERR] %0t run did not finish", $time);
    give_verdict;
  end
endmodule : testbench

bind mesf_core mesf_monitor i_mesf_monitor (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sum1_sign_a(sum1_sign_a), .pulse_raw(pulse_raw),
  .compute_cycle_done(compute_cycle_done), .pulse_out_1_n(pulse_out_1_n),
  .pulse_out_2_n(pulse_out_2_n), .pulse_out_3_n(pulse_out_3_n),
  .pulse1_power_select(pulse1_power_select),
  .pulse2_power_select(pulse2_power_select),
  .pulse3_power_select(pulse3_power_select),
  .interrupt_request_out_n(interrupt_request_out_n)
);
